/* design/irq_level_ctrl.sv */
// Local design decisions: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module irq_level_ctrl (
    // Clock, reset, enable
    input wire logic SYS_CLK,
    input wire logic RST_N,
    input wire logic CE,
    // Wishbone slave
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    output logic INT_O,
    // External request pins, active low
    input wire logic [7:1] EXT_REQ_N,
    // Internal sources
    input wire logic TICK_REQ,
    output logic TICK_ACK,
    input wire logic EDGE_REQ,
    output logic EDGE_ACK,
    // Processor core
    input wire logic [2:0] CPU_MASK,
    output logic [2:0] CPU_LEVEL,
    output logic CPU_NMI,
    input wire logic CPU_ACK_STB,
    input wire logic [2:0] CPU_ACK_LVL,
    // Acknowledge cycle encoding
    output logic [2:0] FUNCTION_CODE_LINES,
    output logic [3:0] ACK_SPACE,
    output logic [2:0] ACK_ADDR_LVL,
    output irq_pkg::src_t ACK_SRC,
    output logic [3:0] ARB_PRIO
);
    import irq_pkg::*;

    req_if rq ();

    logic [2:0] tick_interrupt_control_reg;
    logic [2:0] edge_detect_level_reg;
    logic [3:0] arbitration_priority_field;
    logic [ST_W-1:0] status;
    logic [ST_W-1:0] imask;
    logic nmi_pend;
    logic line7_prev;
    logic [2:0] mask_prev;
    logic top_level_request_line;
    logic nmi_raise;
    logic [7:0] ext_at;
    logic tick_on;
    logic edge_on;
    logic tick_hit;
    logic ext_hit;
    logic edge_hit;
    src_t next_src;
    logic [ST_W-1:0] ev;
    logic wb_req;
    logic wb_wr;
    logic [31:0] next_rdata;

    req_filter u_filter (
        .clk(SYS_CLK),
        .rst_n(RST_N),
        .ce(CE),
        .line_n(EXT_REQ_N),
        .rq(rq.filt)
    );

    level_arbiter u_arb (
        .rq(rq.arb)
    );

    // Request vector per level, from all three sources
    assign top_level_request_line = rq.ext_valid[7];
    assign tick_on = TICK_REQ && (tick_interrupt_control_reg != LVL_NONE);
    assign edge_on = EDGE_REQ && (edge_detect_level_reg != LVL_NONE);
    assign ext_at = {nmi_pend, rq.ext_valid[6:1], 1'b0};

    genvar i;
    generate
        for (i = 1; i <= NUM_LVL; i++) begin : g_req
            localparam logic [2:0] LVL = 3'(i);
            assign rq.lvl_req[i] = ext_at[i]
                | (tick_on && tick_interrupt_control_reg == LVL)
                | (edge_on && edge_detect_level_reg == LVL);
        end
    endgenerate
    assign rq.mask = CPU_MASK;

    // Level 7: raised on a fresh assertion or when the mask leaves 7
    assign nmi_raise = (top_level_request_line && !line7_prev)
        || (top_level_request_line && mask_prev == MASK_MAX
            && CPU_MASK != MASK_MAX);

    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            line7_prev <= 1'b0;
            mask_prev <= LVL_NONE;
            CPU_NMI <= 1'b0;
        end else if (CE) begin
            line7_prev <= top_level_request_line;
            mask_prev <= CPU_MASK;
            CPU_NMI <= nmi_raise;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            nmi_pend <= 1'b0;
        end else if (CE) begin
            // A new raise beats a same-cycle acknowledge
            if (nmi_raise) begin
                nmi_pend <= 1'b1;
            end else if (CPU_ACK_STB && CPU_ACK_LVL == LVL_TOP
                && next_src == SRC_EXT) begin
                nmi_pend <= 1'b0;
            end
        end
    end

    // Presented level is recomputed each clock while CE is high, held while CE is low
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            CPU_LEVEL <= LVL_NONE;
        end else if (CE) begin
            CPU_LEVEL <= rq.top_lvl;
        end
    end

    // Source choice for the acknowledged level
    assign tick_hit = tick_on && tick_interrupt_control_reg == CPU_ACK_LVL;
    assign ext_hit = ext_at[CPU_ACK_LVL];
    assign edge_hit = edge_on && edge_detect_level_reg == CPU_ACK_LVL;

    always_comb begin
        if (tick_hit) begin
            next_src = SRC_TICK;
        end else if (ext_hit) begin
            next_src = SRC_EXT;
        end else if (edge_hit) begin
            next_src = SRC_EDGE;
        end else begin
            next_src = SRC_NONE;
        end
    end

    // Acknowledge cycle outputs; losers stay requested for later
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            FUNCTION_CODE_LINES <= LVL_NONE;
            ACK_SPACE <= 4'h0;
            ACK_ADDR_LVL <= LVL_NONE;
            ACK_SRC <= SRC_NONE;
            TICK_ACK <= 1'b0;
            EDGE_ACK <= 1'b0;
        end else if (CE) begin
            TICK_ACK <= CPU_ACK_STB && next_src == SRC_TICK;
            EDGE_ACK <= CPU_ACK_STB && next_src == SRC_EDGE;
            if (CPU_ACK_STB) begin
                FUNCTION_CODE_LINES <= ACK_FC_CODE;
                ACK_SPACE <= ACK_SPACE_CODE;
                ACK_ADDR_LVL <= CPU_ACK_LVL;
                ACK_SRC <= next_src;
            end
        end
    end

    assign ARB_PRIO = arbitration_priority_field;

    // Events for the status register
    always_comb begin
        ev = '0;
        ev[ST_TICK] = CPU_ACK_STB && next_src == SRC_TICK;
        ev[ST_EXT] = CPU_ACK_STB && next_src == SRC_EXT;
        ev[ST_EDGE] = CPU_ACK_STB && next_src == SRC_EDGE;
        ev[ST_NMI] = nmi_raise;
        ev[ST_SPUR] = CPU_ACK_STB && next_src == SRC_NONE;
    end

    // Wishbone: one wait state, every address answered
    assign wb_req = WB_CYC_I && WB_STB_I;
    assign wb_wr = wb_req && WB_WE_I && !WB_ACK_O;

    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            WB_ACK_O <= 1'b0;
        end else if (CE) begin
            WB_ACK_O <= wb_req && !WB_ACK_O;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            tick_interrupt_control_reg <= LVL_NONE;
            edge_detect_level_reg <= LVL_NONE;
            arbitration_priority_field <= ARB_RESET;
            imask <= '0;
        end else if (CE && wb_wr && WB_SEL_I[0]) begin
            case (WB_ADR_I)
                REG_TICK_CTRL: tick_interrupt_control_reg <= WB_DAT_I[2:0];
                REG_EDGE_LVL: edge_detect_level_reg <= WB_DAT_I[2:0];
                REG_ARB: arbitration_priority_field <= WB_DAT_I[3:0];
                REG_IMASK: imask <= WB_DAT_I[ST_W-1:0];
                default: ;
            endcase
        end
    end

    // Sticky status: write one clears, but a new event wins
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            status <= '0;
        end else if (CE) begin
            if (wb_wr && WB_SEL_I[0] && WB_ADR_I == REG_STATUS) begin
                status <= (status & ~WB_DAT_I[ST_W-1:0]) | ev;
            end else begin
                status <= status | ev;
            end
        end
    end

    always_comb begin
        next_rdata = 32'h0000_0000;
        case (WB_ADR_I)
            REG_TICK_CTRL: next_rdata[2:0] = tick_interrupt_control_reg;
            REG_EDGE_LVL: next_rdata[2:0] = edge_detect_level_reg;
            REG_ARB: next_rdata[3:0] = arbitration_priority_field;
            REG_STATUS: next_rdata[ST_W-1:0] = status;
            REG_IMASK: next_rdata[ST_W-1:0] = imask;
            REG_STATE: begin
                next_rdata[STATE_LVL_HI:STATE_LVL_LO] = CPU_LEVEL;
                next_rdata[STATE_LINE_HI:STATE_LINE_LO] = rq.ext_valid;
                next_rdata[STATE_NMI] = nmi_pend;
            end
            default: next_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            WB_DAT_O <= 32'h0000_0000;
        end else if (CE && wb_req && !WB_ACK_O) begin
            WB_DAT_O <= next_rdata;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            INT_O <= 1'b0;
        end else if (CE) begin
            INT_O <= |(status & imask);
        end
    end
endmodule // irq_level_ctrl

/* design/irq_pkg.sv */
// Functional notes
// - Three internal sources: tick, edge, external unit
// - External lines forwarded as own requests
// - Same level: tick, then external, then edge
// - Line n maps to level n
// - Tick and edge levels programmable, zero disables
// - Levels at or below mask are ignored
// - Level seven always recognized
// - Highest pending level wins
// - External lines active low, level sensitive
// - Level seven needs a falling edge
// - Nonmaskable raise on assertion or mask drop
// - Accept after two consecutive sampled periods
// - Requests stay pending until core takes them
// - Level never latched; higher request overtakes
// - Acknowledge drives code, space type, level
// - Arbitration field resets to highest value
package irq_pkg;
    localparam int NUM_LVL = 7;
    localparam logic [2:0] LVL_NONE = 3'h0;
    localparam logic [2:0] LVL_TOP = 3'h7;
    localparam logic [2:0] MASK_MAX = 3'h7;
    localparam logic [2:0] ACK_FC_CODE = 3'h7;
    localparam logic [3:0] ACK_SPACE_CODE = 4'hF;
    localparam logic [3:0] ARB_RESET = 4'hF;
    // Register byte offsets
    localparam logic [7:0] REG_TICK_CTRL = 8'h00;
    localparam logic [7:0] REG_EDGE_LVL = 8'h04;
    localparam logic [7:0] REG_ARB = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0C;
    localparam logic [7:0] REG_IMASK = 8'h10;
    localparam logic [7:0] REG_STATE = 8'h14;
    // Status and mask bit positions
    localparam int ST_TICK = 0;
    localparam int ST_EXT = 1;
    localparam int ST_EDGE = 2;
    localparam int ST_NMI = 3;
    localparam int ST_SPUR = 4;
    localparam int ST_W = 5;
    // State register field positions
    localparam int STATE_LVL_LO = 0;
    localparam int STATE_LVL_HI = 2;
    localparam int STATE_LINE_LO = 8;
    localparam int STATE_LINE_HI = 14;
    localparam int STATE_NMI = 16;
    typedef enum logic [1:0] {SRC_NONE, SRC_TICK, SRC_EXT, SRC_EDGE} src_t;
endpackage

/* design/level_arbiter.sv */
`timescale 1ns/1ps
module level_arbiter (
    // Requests and mask in, level out
    req_if.arb rq
);
    import irq_pkg::*;
    logic [7:1] pass;

    genvar i;
    generate
        for (i = 1; i <= NUM_LVL; i++) begin : g_lvl
            localparam logic [2:0] LVL = 3'(i);
            assign pass[i] = rq.lvl_req[i] &
                ((LVL > rq.mask) | (LVL == LVL_TOP));
        end
    endgenerate

    always_comb begin
        rq.top_lvl = LVL_NONE;
        for (int l = 1; l <= NUM_LVL; l++) begin
            if (pass[l]) begin
                rq.top_lvl = 3'(l);
            end
        end
    end
endmodule // level_arbiter

/* design/req_filter.sv */
`timescale 1ns/1ps
module req_filter (
    // Clock and control
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // Raw active-low request pins
    input wire logic [7:1] line_n,
    // Filtered requests
    req_if.filt rq
);
    import irq_pkg::*;
    logic [7:1] sync1;
    logic [7:1] sync2;
    logic [7:1] sync3;
    logic [7:1] stable;
    logic [7:1] stable_prev;

    genvar i;
    generate
        for (i = 1; i <= NUM_LVL; i++) begin : g_line
            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    sync1[i] <= 1'b0;
                    sync2[i] <= 1'b0;
                    sync3[i] <= 1'b0;
                    stable[i] <= 1'b0;
                    stable_prev[i] <= 1'b0;
                end else if (ce) begin
                    sync1[i] <= ~line_n[i];
                    sync2[i] <= sync1[i];
                    sync3[i] <= sync2[i];
                    if (sync2[i] == sync3[i]) begin
                        stable[i] <= sync3[i];
                    end
                    stable_prev[i] <= stable[i];
                end
            end
            // Two consecutive asserted periods before the request counts
            assign rq.ext_valid[i] = stable[i] & stable_prev[i];
        end
    endgenerate
endmodule // req_filter

/* design/req_if.sv */
`timescale 1ns/1ps
interface req_if;
    logic [7:1] ext_valid;
    logic [7:1] lvl_req;
    logic [2:0] mask;
    logic [2:0] top_lvl;
    modport filt (output ext_valid);
    modport arb (input lvl_req, input mask, output top_lvl);
    modport core (input ext_valid, input top_lvl, output lvl_req,
        output mask);
endinterface

/* tb/irq_level_ctrl_asserts.sv */
`timescale 1ns/1ps
module irq_level_ctrl_asserts
    import irq_pkg::*;
(
    // Clock and reset
    input wire logic SYS_CLK,
    input wire logic RST_N,
    // Register bus
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_ACK_O,
    // Core side
    input wire logic [2:0] CPU_MASK,
    input wire logic [2:0] CPU_LEVEL,
    input wire logic CPU_NMI,
    input wire logic CPU_ACK_STB,
    input wire logic [2:0] CPU_ACK_LVL,
    // Acknowledge outputs
    input wire logic [2:0] FUNCTION_CODE_LINES,
    input wire logic [3:0] ACK_SPACE,
    input wire logic [2:0] ACK_ADDR_LVL,
    input wire irq_pkg::src_t ACK_SRC,
    input wire logic TICK_ACK,
    input wire logic EDGE_ACK,
    input wire logic [3:0] ARB_PRIO
);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);

    a_level_masked: assert property (
        CPU_LEVEL inside {[3'h1:3'h6]} |-> CPU_LEVEL > $past(CPU_MASK))
        else $error("level at or below mask shown");
    a_ack_code: assert property ($past(CPU_ACK_STB) |->
        FUNCTION_CODE_LINES == ACK_FC_CODE && ACK_SPACE == ACK_SPACE_CODE
        && ACK_ADDR_LVL == $past(CPU_ACK_LVL))
        else $error("acknowledge encoding wrong");
    a_ack_hold: assert property (
        !$past(CPU_ACK_STB) |-> $stable(ACK_ADDR_LVL))
        else $error("acknowledge level moved without ack");
    a_tick_wins: assert property (
        TICK_ACK |-> !EDGE_ACK && ACK_SRC == SRC_TICK)
        else $error("tick ack lost priority");
    a_edge_src: assert property (
        EDGE_ACK |-> ACK_SRC == SRC_EDGE)
        else $error("edge ack with other source");
    // A mask drop right after a fresh raise is a second legal raise
    a_nmi_pulse: assert property (
        CPU_NMI && $stable(CPU_MASK) |=> !CPU_NMI)
        else $error("nmi longer than one cycle");
    a_arb_reset: assert property (disable iff (1'h0)
        !RST_N |=> ARB_PRIO == ARB_RESET)
        else $error("arbitration field reset wrong");
    a_bus_answer: assert property (
        WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
        else $error("bus ack late");
    a_bus_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("bus ack longer than one cycle");
endmodule // irq_level_ctrl_asserts

bind irq_level_ctrl irq_level_ctrl_asserts chk (.*);

/* tb/req_partner.sv */
`timescale 1ns/1ps
module req_partner (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Bench wishes and core acknowledge
    input wire logic [7:1] want,
    input wire logic ack_stb,
    input wire logic [2:0] ack_lvl,
    // Request pins, pulled up when released
    output logic [7:1] line_n
);
    logic [7:1] held;
    logic [7:1] prev;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            held <= 7'h0;
            prev <= 7'h0;
        end else begin
            prev <= want;
            for (int i = 1; i <= 7; i++) begin
                // Only the acknowledge of its own level lets go
                held[i] <= (want[i] & ~prev[i]) |
                    (held[i] & ~(ack_stb && ack_lvl == 3'(i)));
            end
        end
    end
    assign line_n = ~held;
endmodule // req_partner

/* tb/testbench.sv */
`timescale 1ns/1ps
module testbench;
    import irq_pkg::*;
    logic SYS_CLK, RST_N, CE, WB_CYC_I, WB_STB_I, WB_WE_I, WB_ACK_O, INT_O;
    logic TICK_REQ, TICK_ACK, EDGE_REQ, EDGE_ACK, CPU_NMI, CPU_ACK_STB;
    logic [7:0] WB_ADR_I;
    logic [3:0] WB_SEL_I, ACK_SPACE, ARB_PRIO;
    logic [31:0] WB_DAT_I, WB_DAT_O, rd;
    logic [7:1] EXT_REQ_N, want;
    logic [2:0] CPU_MASK, CPU_LEVEL, CPU_ACK_LVL;
    logic [2:0] FUNCTION_CODE_LINES, ACK_ADDR_LVL;
    src_t ACK_SRC;
    int num_errors = 0;
    int check_count = 0;

    irq_level_ctrl uut (.*);
    req_partner far_end (.clk(SYS_CLK), .rst_n(RST_N), .want(want),
        .ack_stb(CPU_ACK_STB), .ack_lvl(CPU_ACK_LVL), .line_n(EXT_REQ_N));

    initial begin
        SYS_CLK = 1'h0;
        forever #10 SYS_CLK = ~SYS_CLK;
    end

    task chk(input string what, input logic [31:0] exp, got);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge SYS_CLK);
        {WB_CYC_I, WB_STB_I, WB_WE_I} <= {2'h3, we};
        WB_ADR_I <= a;
        WB_DAT_I <= d;
        n = 0;
        do begin
            @(posedge SYS_CLK);
            n++;
        end while (WB_ACK_O !== 1'h1 && n < 50);
        if (n >= 50) num_errors++;
        rd = WB_DAT_O;
        {WB_CYC_I, WB_STB_I} <= 2'h0;
    endtask

    task rdc(input logic [7:0] a, input logic [31:0] exp);
        wb(1'h0, a, 32'h0);
        chk("register read", exp, rd);
    endtask

    task ack(input logic [2:0] l);
        @(posedge SYS_CLK);
        CPU_ACK_STB <= 1'h1;
        CPU_ACK_LVL <= l;
        @(posedge SYS_CLK);
        CPU_ACK_STB <= 1'h0;
        @(posedge SYS_CLK);
    endtask

    // Bounded wait for a level, or for an nmi pulse
    task wq(input logic [2:0] l, input logic nmi);
        int n;
        n = 0;
        do begin
            @(posedge SYS_CLK);
            n++;
        end while ((nmi ? CPU_NMI !== 1'h1 : CPU_LEVEL !== l) && n < 30);
        if (nmi) chk("nmi", 32'h1, CPU_NMI);
        else chk("level", l, CPU_LEVEL);
    endtask

    task t_regs;
        chk("arb field", 32'hF, ARB_PRIO);
        rdc(REG_ARB, 32'hF);
        wb(1'h1, REG_ARB, 32'h5);
        chk("arb field", 32'h5, ARB_PRIO);
        wb(1'h1, REG_TICK_CTRL, 32'h3);
        rdc(REG_TICK_CTRL, 32'h3);
        rdc(8'h2C, 32'h0);
    endtask

    task t_tick;
        // Enable low must freeze the presented level
        CE <= 1'h0;
        TICK_REQ <= 1'h1;
        repeat (3) @(posedge SYS_CLK);
        chk("frozen level", 32'h0, CPU_LEVEL);
        CE <= 1'h1;
        wq(3'h3, 1'h0);
        CPU_MASK <= 3'h3;
        wq(3'h0, 1'h0);
        CPU_MASK <= 3'h2;
        wq(3'h3, 1'h0);
        wb(1'h1, REG_TICK_CTRL, 32'h0);
        wq(3'h0, 1'h0);
    endtask

    task t_same;
        wb(1'h1, REG_TICK_CTRL, 32'h4);
        wb(1'h1, REG_EDGE_LVL, 32'h4);
        EDGE_REQ <= 1'h1;
        wq(3'h4, 1'h0);
        ack(3'h4);
        chk("tick vs edge", 32'h2, {TICK_ACK, EDGE_ACK});
        TICK_REQ <= 1'h0;
        ack(3'h4);
        chk("edge later", {1'h1, SRC_EDGE}, {EDGE_ACK, ACK_SRC});
        rdc(REG_STATUS, 32'h5);
        wb(1'h1, REG_IMASK, 32'h1);
        @(posedge SYS_CLK);
        chk("interrupt", 32'h1, INT_O);
        wb(1'h1, REG_STATUS, 32'h1);
        @(posedge SYS_CLK);
        chk("interrupt", 32'h0, INT_O);
        EDGE_REQ <= 1'h0;
        wb(1'h1, REG_EDGE_LVL, 32'h0);
        wb(1'h1, REG_STATUS, 32'h1F);
        CPU_MASK <= 3'h0;
    endtask

    task t_ext;
        want[5] <= 1'h1;
        repeat (3) @(posedge SYS_CLK);
        chk("early level", 32'h0, CPU_LEVEL);
        wq(3'h5, 1'h0);
        want[2] <= 1'h1;
        repeat (10) @(posedge SYS_CLK);
        chk("highest", 32'h5, CPU_LEVEL);
        ack(3'h5);
        chk("ack code", {3'h7, 4'hF, 3'h5, SRC_EXT},
            {FUNCTION_CODE_LINES, ACK_SPACE, ACK_ADDR_LVL, ACK_SRC});
        wq(3'h2, 1'h0);
        ack(3'h2);
        wq(3'h0, 1'h0);
        want <= 7'h0;
    endtask

    task t_nmi;
        int n;
        CPU_MASK <= 3'h7;
        want[7] <= 1'h1;
        wq(3'h0, 1'h1);
        n = 0;
        repeat (10) begin
            @(posedge SYS_CLK);
            if (CPU_NMI === 1'h1) n++;
        end
        chk("repeat nmi", 32'h0, n);
        chk("level", 32'h7, CPU_LEVEL);
        rdc(REG_STATE, 32'h0001_4007);
        CPU_MASK <= 3'h0;
        wq(3'h0, 1'h1);
        ack(3'h7);
        chk("nmi source", SRC_EXT, ACK_SRC);
        wq(3'h0, 1'h0);
        rdc(REG_STATUS, 32'hA);
        ack(3'h3);
        chk("no source", SRC_NONE, ACK_SRC);
        rdc(REG_STATUS, 32'h1A);
        want <= 7'h0;
    endtask

    task finish_test;
        if (num_errors == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    initial begin
        {RST_N, CE, WB_CYC_I, WB_STB_I, WB_WE_I} = 5'h08;
        {TICK_REQ, EDGE_REQ, CPU_ACK_STB} = 3'h0;
        {WB_ADR_I, WB_DAT_I, WB_SEL_I} = {8'h0, 32'h0, 4'hF};
        {CPU_MASK, CPU_ACK_LVL, want} = 13'h0;
        repeat (10) @(posedge SYS_CLK);
        RST_N <= 1'h1;
        t_regs;
        t_tick;
        t_same;
        t_ext;
        t_nmi;
        finish_test;
    end

    // The whole run needs well under two thousand cycles
    initial begin
        repeat (5000) @(posedge SYS_CLK);
        num_errors++;
        finish_test;
    end
endmodule // testbench
